// ---- design/crf_core_regs.sv ----
/*
  Programmer-visible register set of a 16-bit core: two banks of data,
  address and frame-base registers, vector table base, instruction
  pointer, two stack pointers, static base and the flag word, reachable
  from software over AXI4-Lite, plus an address region decoder.
  Assumes the core's execution logic runs on aclk and drives the core-side
  inputs synchronously, so none of them needs a synchroniser.
*/
// Operation
// RL1: thirteen registers, seven duplicated in two banks.
// RL2: sixteen-bit data registers, byte halves separately accessible.
// RL3: data pairs form 32 bits, higher register upper.
// RL4: address pair forms 32 bits, second upper.
// RL5: frame base and static base sixteen bits.
// RL6: vector table base is twenty bits.
// RL7: instruction pointer is twenty bits.
// RL8: stack select picks interrupt or user pointer.
// RL9: stack select cleared on interrupt acknowledge.
// RL10: flag register holds eleven state bits.
// RL11: carry flag captures ALU carry out.
// RL12: zero flag set on zero result.
// RL13: sign flag set on negative result.
// RL14: overflow flag set on overflow.
// RL15: bank flag routes banked register accesses.
// RL16: enable flag gates, cleared on acknowledge.
// RL17: request enabled only above priority level.
// RL18: software keeps the debug flag zero.
// RL19: reserved flag bit written zero, reads undefined.
// RL20: peripheral space and RAM placement decoded.
// RL21: program ROM and vector table placement decoded.
// RL22: data flash region mapped when present.
// RL23: bank switching leaves contents untouched.
`include "crf_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module crf_core_regs
  import crf_pkg::*;
#(
  parameter bit HAS_DATA_FLASH = 1'b1,
  parameter int RAM_BYTES = 1024,
  parameter int ROM_BYTES = 16384
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side.
  input wire logic alu_flags_we,
  input wire logic [15:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  input wire logic hw_irq_ack,
  input wire logic swi_exec,
  input wire logic [5:0] swi_num,
  input wire logic irq_req,
  input wire logic [2:0] irq_prio,
  input wire logic pc_load,
  input wire logic [19:0] pc_next,
  input wire logic [19:0] mem_addr,
  output logic [10:0] flags_out,
  output logic [15:0] active_sp,
  output logic irq_accept,
  output logic [2:0] mem_region
);

  // ============================================================
  // Address map bounds at address width
  // ============================================================
  // Sizes are cut to the address width once so the decoder compares
  // twenty-bit values only.
  localparam logic [19:0] RAM_SIZE = RAM_BYTES[19:0];
  localparam logic [19:0] ROM_SIZE = ROM_BYTES[19:0];
  localparam logic [19:0] RAM_LAST = `CRF_MAP_RAM_BASE + RAM_SIZE - 20'h00001;
  localparam logic [19:0] ROM_FIRST = `CRF_MAP_ROM_END - ROM_SIZE + 20'h00001;

  // Registered state and its next value.
  crf_state_t st_q;
  crf_state_t st_d;

  // ============================================================
  // Helper functions
  // ============================================================

  // Merges a written word into an old one under the byte strobes, so each
  // byte lane of a register stands on its own.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        res[k*8 +: 8] = wd[k*8 +: 8];
      end
    end
    return res;
  endfunction

  // Packs the flag record into its bus word; the reserved bit reads zero.
  function automatic logic [31:0] flag_word(input crf_flags_t f);
    logic [31:0] w;
    w = `CRF_RST_WORD;
    w[`CRF_FLG_C] = f.c;
    w[`CRF_FLG_D] = f.d;
    w[`CRF_FLG_Z] = f.z;
    w[`CRF_FLG_S] = f.s;
    w[`CRF_FLG_B] = f.b;
    w[`CRF_FLG_O] = f.o;
    w[`CRF_FLG_I] = f.i;
    w[`CRF_FLG_U] = f.u;
    w[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO] = f.cpu_priority_level;
    return w;
  endfunction

  // Unpacks a bus word into the flag record; the reserved bit is dropped.
  function automatic crf_flags_t word_flag(input logic [31:0] w);
    crf_flags_t f;
    f.c = w[`CRF_FLG_C];
    f.d = w[`CRF_FLG_D];
    f.z = w[`CRF_FLG_Z];
    f.s = w[`CRF_FLG_S];
    f.b = w[`CRF_FLG_B];
    f.o = w[`CRF_FLG_O];
    f.i = w[`CRF_FLG_I];
    f.u = w[`CRF_FLG_U];
    f.cpu_priority_level = w[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO];
    return f;
  endfunction

  // Read mux over the current state; returns the decode hit in bit 32.
  function automatic logic [32:0] read_word(input crf_state_t s,
                                            input logic [7:0] a);
    crf_bank_t bk;
    logic [32:0] r;
    bk = s.bank[s.cpu_flags.b]; // RL15
    r = {1'b1, `CRF_RST_WORD};
    unique case (a)
      `CRF_OFS_DATA0: r[15:0] = bk.dat[0]; // RL2
      `CRF_OFS_DATA1: r[15:0] = bk.dat[1];
      `CRF_OFS_DATA2: r[15:0] = bk.dat[2];
      `CRF_OFS_DATA3: r[15:0] = bk.dat[3];
      `CRF_OFS_ADDR0: r[15:0] = bk.adr[0];
      `CRF_OFS_ADDR1: r[15:0] = bk.adr[1];
      `CRF_OFS_FRAME: r[15:0] = bk.fb; // RL5
      `CRF_OFS_VTB: r[19:0] = s.vtb; // RL6
      `CRF_OFS_IP: r[19:0] = s.ip; // RL7
      `CRF_OFS_USP: r[15:0] = s.user_stack_ptr;
      `CRF_OFS_ISP: r[15:0] = s.irq_stack_ptr;
      `CRF_OFS_SB: r[15:0] = s.sb; // RL5
      `CRF_OFS_FLAGS: r[31:0] = flag_word(s.cpu_flags); // RL10 RL19
      `CRF_OFS_WIDE_DATA: r[31:0] = {bk.dat[2], bk.dat[0]}; // RL3
      `CRF_OFS_WIDE_ALT: r[31:0] = {bk.dat[3], bk.dat[1]}; // RL3
      `CRF_OFS_WIDE_ADDR: r[31:0] = {bk.adr[1], bk.adr[0]}; // RL4
      `CRF_OFS_ACTIVE_SP: r[15:0] = s.sp_act;
      default: r = {1'b0, `CRF_RST_WORD};
    endcase
    return r;
  endfunction

  // ============================================================
  // Next-state logic
  // ============================================================
  // Order inside the process: write handshakes, a pending bus write, the read channel, then
  // core events. Core events come last so that an interrupt acknowledge or
  // an ALU flag update in the same cycle as a software write to the flag
  // word still takes effect; losing such an event would corrupt the
  // interrupt nesting.
  always_comb begin
    crf_bank_t bk;
    logic [31:0] wide;
    logic [32:0] rd;
    logic hit;
    bk = '0;
    wide = `CRF_RST_WORD;
    rd = '0;
    hit = 1'b0;
    st_d = st_q;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_hold = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_hold = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end

    // A write response retires when the master takes it.
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Both halves held and no response pending: perform the write.
    if (st_q.aw_hold && st_q.w_hold && !st_q.bvalid) begin
      // Only the bank the select flag names is touched; the other bank
      // keeps its contents across any number of switches.
      bk = st_q.bank[st_q.cpu_flags.b]; // RL1 RL15 RL23
      hit = 1'b1;
      unique case (st_q.aw_addr)
        `CRF_OFS_DATA0: bk.dat[0] = 16'(merge({16'h0000, bk.dat[0]}, st_q.w_data,
                                              st_q.w_strb)); // RL2
        `CRF_OFS_DATA1: bk.dat[1] = 16'(merge({16'h0000, bk.dat[1]}, st_q.w_data,
                                              st_q.w_strb)); // RL2
        `CRF_OFS_DATA2: bk.dat[2] = 16'(merge({16'h0000, bk.dat[2]}, st_q.w_data,
                                              st_q.w_strb));
        `CRF_OFS_DATA3: bk.dat[3] = 16'(merge({16'h0000, bk.dat[3]}, st_q.w_data,
                                              st_q.w_strb));
        `CRF_OFS_ADDR0: bk.adr[0] = 16'(merge({16'h0000, bk.adr[0]}, st_q.w_data,
                                              st_q.w_strb));
        `CRF_OFS_ADDR1: bk.adr[1] = 16'(merge({16'h0000, bk.adr[1]}, st_q.w_data,
                                              st_q.w_strb));
        `CRF_OFS_FRAME: bk.fb = 16'(merge({16'h0000, bk.fb}, st_q.w_data,
                                          st_q.w_strb)); // RL5
        `CRF_OFS_VTB: st_d.vtb = 20'(merge({12'h000, st_q.vtb}, st_q.w_data,
                                           st_q.w_strb)); // RL6
        `CRF_OFS_IP: st_d.ip = 20'(merge({12'h000, st_q.ip}, st_q.w_data,
                                         st_q.w_strb)); // RL7
        `CRF_OFS_USP: st_d.user_stack_ptr = 16'(merge({16'h0000, st_q.user_stack_ptr}, st_q.w_data,
                                           st_q.w_strb)); // RL8
        `CRF_OFS_ISP: st_d.irq_stack_ptr = 16'(merge({16'h0000, st_q.irq_stack_ptr}, st_q.w_data,
                                           st_q.w_strb)); // RL8
        `CRF_OFS_SB: st_d.sb = 16'(merge({16'h0000, st_q.sb}, st_q.w_data,
                                         st_q.w_strb)); // RL5
        `CRF_OFS_FLAGS: begin
          // The reserved bit has no storage, so whatever is written there
          // is lost; the debug flag is stored as software writes it.
          st_d.cpu_flags = word_flag(merge(flag_word(st_q.cpu_flags), st_q.w_data,
                                     st_q.w_strb)); // RL10 RL19
        end
        `CRF_OFS_WIDE_DATA: begin
          wide = merge({bk.dat[2], bk.dat[0]}, st_q.w_data, st_q.w_strb);
          bk.dat[2] = wide[31:16]; // RL3
          bk.dat[0] = wide[15:0];
        end
        `CRF_OFS_WIDE_ALT: begin
          wide = merge({bk.dat[3], bk.dat[1]}, st_q.w_data, st_q.w_strb);
          bk.dat[3] = wide[31:16]; // RL3
          bk.dat[1] = wide[15:0];
        end
        `CRF_OFS_WIDE_ADDR: begin
          wide = merge({bk.adr[1], bk.adr[0]}, st_q.w_data, st_q.w_strb);
          bk.adr[1] = wide[31:16]; // RL4
          bk.adr[0] = wide[15:0];
        end
        default: hit = 1'b0;
      endcase
      st_d.bank[st_q.cpu_flags.b] = bk; // RL23
      st_d.aw_hold = 1'b0;
      st_d.w_hold = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = hit ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
    end

    // A read retires when the master takes the data.
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // A read is taken only while no data is pending, answered next edge.
    if (s_axi_arvalid && st_q.arready) begin
      rd = read_word(st_q, s_axi_araddr);
      st_d.rvalid = 1'b1;
      st_d.rdata = rd[31:0];
      st_d.rresp = rd[32] ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
    end

    // Core writes the instruction pointer after the bus so it wins.
    if (pc_load) begin
      st_d.ip = pc_next; // RL7
    end

    // ALU result flags.
    if (alu_flags_we) begin
      st_d.cpu_flags.c = alu_carry; // RL11
      st_d.cpu_flags.z = (alu_result == 16'h0000); // RL12
      st_d.cpu_flags.s = alu_result[15]; // RL13
      st_d.cpu_flags.o = alu_overflow; // RL14
    end

    // Any acknowledged interrupt masks further maskable requests.
    if (hw_irq_ack || swi_exec) begin
      st_d.cpu_flags.i = 1'b0; // RL16
    end
    // Hardware interrupts and the low software vectors run on the
    // interrupt stack.
    if (hw_irq_ack || (swi_exec && swi_num <= `CRF_SWI_U_LAST)) begin
      st_d.cpu_flags.u = 1'b0; // RL9
    end

    // Handshake readiness follows the hold registers and the read valid of the next cycle.
    st_d.awready = !st_d.aw_hold;
    st_d.wready = !st_d.w_hold;
    st_d.arready = !st_d.rvalid;

    // Registered views for the core, one cycle behind the state.
    st_d.sp_act = st_q.cpu_flags.u ? st_q.user_stack_ptr : st_q.irq_stack_ptr; // RL8
    st_d.irq_ok = irq_req && st_q.cpu_flags.i && (irq_prio > st_q.cpu_flags.cpu_priority_level); // RL16 RL17

    // Region of the core address.
    if (mem_addr <= `CRF_MAP_SFR_END) begin
      st_d.region = CRF_RGN_SFR; // RL20
    end else if (mem_addr >= `CRF_MAP_RAM_BASE && mem_addr <= RAM_LAST) begin
      st_d.region = CRF_RGN_RAM; // RL20
    end else if (HAS_DATA_FLASH && mem_addr >= `CRF_MAP_DF_BASE &&
                 mem_addr <= `CRF_MAP_DF_END) begin
      st_d.region = CRF_RGN_DFLASH; // RL22
    end else if (mem_addr >= `CRF_MAP_VECT_BASE &&
                 mem_addr <= `CRF_MAP_ROM_END) begin
      st_d.region = CRF_RGN_VECT; // RL21
    end else if (mem_addr >= ROM_FIRST && mem_addr <= `CRF_MAP_ROM_END) begin
      st_d.region = CRF_RGN_ROM; // RL21
    end else begin
      st_d.region = CRF_RGN_RSVD; // RL20
    end
  end

  // ============================================================
  // State register
  // ============================================================
  // Synchronous reset clears everything; clock enable low freezes all.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Outputs, straight from the state register
  // ============================================================
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign flags_out = st_q.cpu_flags; // RL10
  assign active_sp = st_q.sp_act;
  assign irq_accept = st_q.irq_ok;
  assign mem_region = st_q.region;

endmodule

`default_nettype wire

// ---- include/crf_defines.svh ----
/*
  Constants of the core register file: register offsets on the register
  bus, flag field positions, reset values and address map boundaries.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses, one aligned word each)
// ============================================================
`define CRF_OFS_DATA0      8'h00
`define CRF_OFS_DATA1      8'h04
`define CRF_OFS_DATA2      8'h08
`define CRF_OFS_DATA3      8'h0C
`define CRF_OFS_ADDR0      8'h10
`define CRF_OFS_ADDR1      8'h14
`define CRF_OFS_FRAME      8'h18
`define CRF_OFS_VTB        8'h1C
`define CRF_OFS_IP         8'h20
`define CRF_OFS_USP        8'h24
`define CRF_OFS_ISP        8'h28
`define CRF_OFS_SB         8'h2C
`define CRF_OFS_FLAGS      8'h30
`define CRF_OFS_WIDE_DATA  8'h34
`define CRF_OFS_WIDE_ALT   8'h38
`define CRF_OFS_WIDE_ADDR  8'h3C
`define CRF_OFS_ACTIVE_SP  8'h40

// ============================================================
// Flag word field positions
// ============================================================
`define CRF_FLG_C          0
`define CRF_FLG_D          1
`define CRF_FLG_Z          2
`define CRF_FLG_S          3
`define CRF_FLG_B          4
`define CRF_FLG_O          5
`define CRF_FLG_I          6
`define CRF_FLG_U          7
`define CRF_FLG_RSVD       8
`define CRF_FLG_IPL_LO     12
`define CRF_FLG_IPL_HI     14

// ============================================================
// Reset values and bus answers
// ============================================================
`define CRF_RST_WORD       32'h0000_0000
`define CRF_RESP_OKAY      2'b00
`define CRF_RESP_SLVERR    2'b10
`define CRF_SWI_U_LAST     6'h1F

// ============================================================
// Address map
// ============================================================
`define CRF_MAP_SFR_END    20'h002FF
`define CRF_MAP_RAM_BASE   20'h00400
`define CRF_MAP_DF_BASE    20'h02400
`define CRF_MAP_DF_END     20'h02BFF
`define CRF_MAP_ROM_END    20'h0FFFF
`define CRF_MAP_VECT_BASE  20'h0FFDC

`endif

// ---- include/crf_pkg.sv ----
/*
  Types of the core register file: bank contents, flags, address regions
  and the one packed state record of the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package crf_pkg;

  // ============================================================
  // Banked registers: four data, two address, one frame base.
  // ============================================================
  typedef struct packed {
    logic [3:0][15:0] dat;
    logic [1:0][15:0] adr;
    logic [15:0] fb;
  } crf_bank_t;

  // ============================================================
  // Processor flags, eleven stored bits.
  // ============================================================
  typedef struct packed {
    logic [2:0] cpu_priority_level;
    logic u;
    logic i;
    logic o;
    logic b;
    logic s;
    logic z;
    logic d;
    logic c;
  } crf_flags_t;

  // Region reported for a core address.
  typedef enum logic [2:0] {
    CRF_RGN_SFR = 3'b000,
    CRF_RGN_RAM = 3'b001,
    CRF_RGN_DFLASH = 3'b010,
    CRF_RGN_ROM = 3'b011,
    CRF_RGN_VECT = 3'b100,
    CRF_RGN_RSVD = 3'b101
  } crf_region_t;

  // ============================================================
  // Whole state of the top module.
  // ============================================================
  typedef struct packed {
    crf_bank_t [1:0] bank;
    logic [19:0] vtb;
    logic [19:0] ip;
    logic [15:0] user_stack_ptr;
    logic [15:0] irq_stack_ptr;
    logic [15:0] sb;
    crf_flags_t cpu_flags;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] sp_act;
    logic irq_ok;
    crf_region_t region;
  } crf_state_t;

endpackage

// ---- verification/crf_core_regs_bench.sv ----
/*
  Self-checking bench of the core register file.
  Assumes design, package and header are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module crf_core_regs_bench;
  // ============================================================
  // Stimulus and observed signals
  // ============================================================
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_accept;
  logic [1:0] bresp, rresp;
  logic alu_we = 1'b0, alu_c = 1'b0, alu_o = 1'b0, hw_ack = 1'b0, swi = 1'b0;
  logic irq_req = 1'b0, pc_load = 1'b0;
  logic [15:0] alu_res = 16'h0, active_sp;
  logic [5:0] swi_num = 6'h00;
  logic [2:0] irq_prio = 3'h0, mem_region;
  logic [19:0] pc_next = 20'h0, mem_addr = 20'h0;
  logic [10:0] flags_out;
  int error_cnt = 0, n_compared = 0;
  // Region probes and their expected codes.
  logic [19:0] rg_a [0:9] = '{20'h00000, 20'h002FF, 20'h00300, 20'h00400, 20'h007FF,
    20'h00800, 20'h02400, 20'h02BFF, 20'h0C000, 20'h0FFDC};
  logic [2:0] rg_e [0:9] = '{3'h0, 3'h0, 3'h5, 3'h1, 3'h1, 3'h5, 3'h2, 3'h2, 3'h3, 3'h4};

  // Free-running clock of 4 ns.
  initial forever #2 aclk = ~aclk;

  crf_core_regs crf_core_regs_i (.*,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alu_flags_we(alu_we), .alu_result(alu_res), .alu_carry(alu_c), .alu_overflow(alu_o),
    .hw_irq_ack(hw_ack), .swi_exec(swi));

  // ============================================================
  // Tasks
  // ============================================================
  // Compare and count; !== so an unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The single exit of the run.
  task automatic end_sim();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One write; the leading edge parts two drives of bready.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  // One read under a bound.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Ends core pulses after one edge; samples at the falling edge.
  task automatic tick();
    @(posedge aclk);
    alu_we <= 1'b0;
    hw_ack <= 1'b0;
    swi <= 1'b0;
    pc_load <= 1'b0;
    @(negedge aclk);
  endtask

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i <= 16; i++) axi_rd(8'(4 * i), 32'h0, 2'b00);
    axi_rd(8'h44, 32'h0, 2'b10);
    axi_wr(8'h40, 32'h1, 4'hF, 2'b10);
    for (int i = 0; i < 12; i++) axi_wr(8'(4 * i), {16'hFFFF, 16'(16'h1111 * (i + 1))},
      4'hF, 2'b00);
    for (int i = 0; i < 12; i++) axi_rd(8'(4 * i), {16'hFFFF, 16'(16'h1111 * (i + 1))} &
      ((i == 7 || i == 8) ? 32'h000F_FFFF : 32'h0000_FFFF), 2'b00);
    axi_rd(8'h34, 32'h3333_1111, 2'b00);
    axi_rd(8'h38, 32'h4444_2222, 2'b00);
    axi_rd(8'h3C, 32'h6666_5555, 2'b00);
    axi_wr(8'h00, 32'h0000_AB00, 4'h2, 2'b00);
    axi_rd(8'h00, 32'h0000_AB11, 2'b00);
    // Bank 1 starts empty; bank 0 keeps its value.
    axi_wr(8'h30, 32'h0000_0010, 4'hF, 2'b00);
    axi_rd(8'h00, 32'h0, 2'b00);
    axi_wr(8'h00, 32'h0000_7777, 4'hF, 2'b00);
    axi_wr(8'h30, 32'h0, 4'hF, 2'b00);
    axi_rd(8'h00, 32'h0000_AB11, 2'b00);
    // Zero with carry, then negative with overflow.
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      alu_res <= (i == 1) ? 16'h8000 : 16'h0000;
      alu_c <= (i == 0);
      alu_o <= (i == 1);
      alu_we <= 1'b1;
      tick();
      chk(32'(flags_out[5:0]), (i == 1) ? 32'h28 : 32'h05);
    end
    axi_wr(8'h24, 32'h1234, 4'hF, 2'b00);
    axi_wr(8'h28, 32'h5678, 4'hF, 2'b00);
    // Hardware acknowledge, software number 31, then number 32.
    for (int k = 0; k < 3; k++) begin
      axi_wr(8'h30, 32'h0000_00C0, 4'hF, 2'b00);
      axi_rd(8'h40, 32'h1234, 2'b00);
      @(posedge aclk);
      hw_ack <= (k == 0);
      swi <= (k != 0);
      swi_num <= (k == 1) ? 6'h1F : 6'h20;
      tick();
      chk(32'(flags_out[7:6]), (k == 2) ? 32'h2 : 32'h0);
      @(negedge aclk);
      chk(32'(active_sp), (k == 2) ? 32'h1234 : 32'h5678);
    end
    axi_wr(8'h30, 32'h0000_3040, 4'hF, 2'b00);
    axi_rd(8'h30, 32'h0000_3040, 2'b00);
    for (int p = 0; p < 8; p++) begin
      @(posedge aclk);
      irq_req <= 1'b1;
      irq_prio <= 3'(p);
      @(posedge aclk);
      @(negedge aclk);
      chk(32'(irq_accept), 32'(p > 3));
    end
    axi_wr(8'h30, 32'h0000_3000, 4'hF, 2'b00);
    @(negedge aclk);
    chk(32'(irq_accept), 32'h0);
    @(posedge aclk);
    pc_next <= 20'hABCDE;
    pc_load <= 1'b1;
    tick();
    axi_rd(8'h20, 32'h000A_BCDE, 2'b00);
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      mem_addr <= rg_a[i];
      @(posedge aclk);
      @(negedge aclk);
      chk(32'(mem_region), 32'(rg_e[i]));
    end
    end_sim();
  end
endmodule

`default_nettype wire

// ---- verification/crf_core_regs_sva.sv ----
/*
  Port checker of the core register file: bus handshakes, flags, interrupt gate.
  Assumes a bind into the design; sees its ports only.
*/
`include "crf_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module crf_core_regs_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic alu_flags_we,
  input wire logic [15:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  input wire logic hw_irq_ack,
  input wire logic swi_exec,
  input wire logic [5:0] swi_num,
  input wire logic irq_req,
  input wire logic [2:0] irq_prio,
  input wire logic [10:0] flags_out,
  input wire logic irq_accept
);
  // ============================================================
  // Clocking and the steps that the properties are built from
  // ============================================================
  // One clock domain: one default clocking.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write address and data taken together.
  sequence wr_take_sq;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      (!s_axi_bvalid || s_axi_bready);
  endsequence
  // A read address taken.
  sequence rd_take_sq;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence

  // ============================================================
  // Assertions
  // ============================================================
  write_answer_a: assert property (wr_take_sq ##1 ce |=> s_axi_bvalid)
    else $error("write response late");
  aw_closed_a: assert property (ce && s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stuck");
  bresp_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response dropped");
  read_answer_a: assert property (rd_take_sq |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rdata_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  read_unmapped_a: assert property (rd_take_sq and s_axi_araddr > 8'h40 |=>
    s_axi_rresp == `CRF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read taken");
  alu_flags_a: assert property (ce && alu_flags_we |=>
    flags_out[0] == $past(alu_carry) && flags_out[2] == ($past(alu_result) == 16'h0000) &&
    flags_out[3] == $past(alu_result[15]) && flags_out[5] == $past(alu_overflow))
    else $error("ALU flags wrong");
  hw_ack_a: assert property (ce && hw_irq_ack |=> flags_out[7:6] == 2'b00)
    else $error("acknowledge flags wrong");
  swi_low_a: assert property (ce && swi_exec && swi_num <= 6'h1F |=>
    flags_out[7:6] == 2'b00)
    else $error("low software vector flags wrong");
  irq_refuse_a: assert property ((ce && irq_req && irq_prio <= flags_out[10:8]) ##1
    $stable(flags_out) |-> !irq_accept)
    else $error("low priority accepted");
  irq_grant_a: assert property ((ce && irq_req && flags_out[6] && irq_prio > flags_out[10:8])
    ##1 $stable(flags_out) |-> irq_accept)
    else $error("enabled request refused");
endmodule

bind crf_core_regs crf_core_regs_sva crf_core_regs_sva_i (.*);

`default_nettype wire
